// file: core/teal_attention_unit.sv
// error, attention and exception logic of one tape formatter drive
//
// Summary of operation
// RL1: erase, space, tape mark completion flag attention
// RL2: rewind start flags attention immediately
// RL3: go with error present flags attention
// RL4: op end after error or slave change
// RL5: op end after end marker flags attention
// RL6: controller reads summary, services, clears flags
// RL7: controller reads status, then error register
// RL8: controller polls slaves on slave change
// RL9: error during transfer raises fault line
// RL10: read error ends block, tape read continues
// RL11: write error ends block, gap, stop
// RL12: transfer tried with prior error ends block
// RL13: error during transfer start ends block
// RL14: unsafe, incomplete, timing, bad function end block
// RL15: data errors end block only when enabled
// RL16: bits 00-05 hold bus and format errors
// RL17: bits 11, 12, 14 hold drive errors
// RL18: frame count bit 09, incomplete bit 13
// RL19: lost medium or low AC sets unsafe
// RL20: reads only bad register; summary writes limited
// RL21: other writes raise three errors only
// RL22: control load with composite fault is refused
// RL23: summary read drives flag on unit line
// RL24: summary write high bit clears flag
// RL25: service request follows the attention flag
`timescale 1ns/100ps
`include "teal_regs.svh"
module teal_attention_unit (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic [2:0] unit_num_i,
   input wire logic drive_sel_match_i,
   input wire logic reg_strobe_i,
   input wire logic reg_write_i,
   input wire logic [4:0] reg_sel_i,
   input wire logic [15:0] ctl_data_i,
   input wire logic ctl_parity_err_i,
   output logic [15:0] ctl_data_o,
   output logic ctl_oe_o,
   output logic reg_ack_o,
   output logic service_request_line_o,
   output logic drive_busy_line_o,
   output logic transfer_fault_line_o,
   output logic end_of_block_line_o,
   output logic motion_start_o,
   output logic [4:0] function_o,
   output logic write_end_o,
   input wire logic op_done_i,
   input wire logic gap_done_i,
   input wire logic medium_on_line_i,
   input wire logic ac_power_low_i,
   input wire logic end_marker_i,
   input wire logic slave_change_i,
   input wire logic format_err_i,
   input wire logic data_parity_err_i,
   input wire logic frame_count_err_i,
   input wire logic unrunnable_err_i,
   input wire logic timing_err_i,
   input wire logic op_incomplete_err_i,
   input wire logic vpar_err_i,
   input wire logic lchk_err_i,
   input wire logic cchk_err_i
);

   teal_pkg::teal_state_e state_q;
   teal_pkg::teal_func_e fn_q;
   teal_pkg::teal_func_e fn_new;
   logic attention_active_flag_q;
   logic slave_change_flag_q;
   logic op_event_q;
   logic fault_q;
   logic ebl_q;
   logic ebl_sent_q;
   logic go_q;
   logic [15:0] maint_q;
   logic [15:0] tape_ctl_q;
   logic [15:0] err_q;
   logic [15:0] err_set;
   logic composite_fault;
   logic acc_ok, rd, wr, legal, wr_ok, busy_any, xfer_busy;
   logic ctl_load, go_load, prior_fault_block, fn_ok, fn_data, fn_write, fn_motion;
   logic ilf_set, ilr_set, rmr_set, control_parity_error_set, start, drv_clear;
   logic any_err_set, invalid, ebl_fire, op_end, service_request_line_set, service_request_line_clear, abort_wr;

   assign fn_new = teal_pkg::teal_func_e'(ctl_data_i[`TEAL_CTL_FN_MSB:`TEAL_CTL_FN_LSB]);

   always_comb begin
      fn_ok = 1'b1;
      case (fn_new)
         teal_pkg::TEAL_FN_NOP, teal_pkg::TEAL_FN_REWIND, teal_pkg::TEAL_FN_DRV_CLEAR,
         teal_pkg::TEAL_FN_ERASE, teal_pkg::TEAL_FN_WR_MARK, teal_pkg::TEAL_FN_SPACE_FWD,
         teal_pkg::TEAL_FN_SPACE_REV, teal_pkg::TEAL_FN_WR_CHECK, teal_pkg::TEAL_FN_WRITE,
         teal_pkg::TEAL_FN_READ_FWD, teal_pkg::TEAL_FN_READ_REV: fn_ok = 1'b1;
         default: fn_ok = 1'b0;
      endcase
   end

   assign fn_data = (fn_new == teal_pkg::TEAL_FN_WR_CHECK) || (fn_new == teal_pkg::TEAL_FN_WRITE) ||
                    (fn_new == teal_pkg::TEAL_FN_READ_FWD) || (fn_new == teal_pkg::TEAL_FN_READ_REV);
   assign fn_write = (fn_q == teal_pkg::TEAL_FN_WRITE);
   assign fn_motion = (fn_q == teal_pkg::TEAL_FN_ERASE) || (fn_q == teal_pkg::TEAL_FN_WR_MARK) ||
                      (fn_q == teal_pkg::TEAL_FN_SPACE_FWD) || (fn_q == teal_pkg::TEAL_FN_SPACE_REV);

   // summary register answers without a drive select
   assign acc_ok = reg_strobe_i & (drive_sel_match_i | (reg_sel_i == `TEAL_IDX_SERVICE_REQUEST_LINE_SUM)); // see RL23
   assign rd = acc_ok & ~reg_write_i;
   assign wr = acc_ok & reg_write_i;
   assign legal = (reg_sel_i <= `TEAL_IDX_TAPE_CTL);
   assign busy_any = (state_q != teal_pkg::TEAL_IDLE);
   assign xfer_busy = (state_q == teal_pkg::TEAL_XSTART) || (state_q == teal_pkg::TEAL_XFER) ||
                      (state_q == teal_pkg::TEAL_WEND);

   assign ilr_set = acc_ok & ~legal; // see RL20
   assign control_parity_error_set = wr & ctl_parity_err_i; // see RL20
   assign wr_ok = wr & legal & ~ctl_parity_err_i;
   // summary and maintenance writes never refuse, so they raise no modify error
   assign rmr_set = wr_ok & busy_any &
                    ((reg_sel_i == `TEAL_IDX_CTRL) || (reg_sel_i == `TEAL_IDX_TAPE_CTL)); // see RL21
   assign ctl_load = wr_ok & ~busy_any & (reg_sel_i == `TEAL_IDX_CTRL);
   assign go_load = ctl_load & ctl_data_i[`TEAL_CTL_GO];
   assign prior_fault_block = go_load & composite_fault; // see RL22
   assign ilf_set = go_load & ~composite_fault & ~fn_ok;
   assign start = go_load & ~composite_fault & fn_ok;
   assign drv_clear = start & (fn_new == teal_pkg::TEAL_FN_DRV_CLEAR);

   always_comb begin
      err_set = 16'h0000;
      err_set[`TEAL_EB_BAD_FN] = ilf_set; // see RL16
      err_set[`TEAL_EB_BAD_REG] = ilr_set; // see RL16
      err_set[`TEAL_EB_MOD_REFUSED] = rmr_set; // see RL16
      err_set[`TEAL_EB_CTL_PAR] = control_parity_error_set; // see RL16
      err_set[`TEAL_EB_FORMAT] = format_err_i; // see RL16
      err_set[`TEAL_EB_DATA_PAR] = data_parity_err_i; // see RL16
      err_set[`TEAL_EB_VPAR] = vpar_err_i;
      err_set[`TEAL_EB_LCHK] = lchk_err_i;
      err_set[`TEAL_EB_CCHK] = cchk_err_i;
      err_set[`TEAL_EB_FRAME_CNT] = frame_count_err_i; // see RL18
      err_set[`TEAL_EB_OP_INCOMPLETE] = op_incomplete_err_i; // see RL18
      err_set[`TEAL_EB_UNRUNNABLE] = unrunnable_err_i; // see RL17
      err_set[`TEAL_EB_TIMING] = timing_err_i; // see RL17
      err_set[`TEAL_EB_NOT_SAFE] = ~medium_on_line_i | ac_power_low_i; // see RL17 see RL19
   end

   teal_error_reg #(
      .WIDTH(16)
   ) u_err (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .set_i(err_set),
      .clear_i(drv_clear),
      .err_o(err_q),
      .composite_o(composite_fault)
   );

   assign any_err_set = |err_set;
   assign invalid = (|(err_set & `TEAL_INVALID_MASK)) | // see RL14
                    ((|(err_set & `TEAL_DATA_MASK)) & tape_ctl_q[`TEAL_TC_ABORT_EN]); // see RL15
   assign abort_wr = fn_write & (((state_q == teal_pkg::TEAL_XSTART) & any_err_set) |
                                 ((state_q == teal_pkg::TEAL_XFER) & invalid));
   assign op_end = (((state_q == teal_pkg::TEAL_MOTION) || (state_q == teal_pkg::TEAL_XFER)) & op_done_i & ~abort_wr) |
                   ((state_q == teal_pkg::TEAL_WEND) & gap_done_i);

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_q <= teal_pkg::TEAL_IDLE;
      end else begin
         case (state_q)
            teal_pkg::TEAL_IDLE: begin
               if (start && fn_data) begin
                  state_q <= teal_pkg::TEAL_XSTART;
               end else if (start && ((fn_new == teal_pkg::TEAL_FN_ERASE) ||
                                      (fn_new == teal_pkg::TEAL_FN_WR_MARK) ||
                                      (fn_new == teal_pkg::TEAL_FN_SPACE_FWD) ||
                                      (fn_new == teal_pkg::TEAL_FN_SPACE_REV))) begin
                  state_q <= teal_pkg::TEAL_MOTION;
               end
            end
            teal_pkg::TEAL_MOTION: begin
               if (op_done_i) begin
                  state_q <= teal_pkg::TEAL_IDLE;
               end
            end
            teal_pkg::TEAL_XSTART: begin
               state_q <= abort_wr ? teal_pkg::TEAL_WEND : teal_pkg::TEAL_XFER;
            end
            teal_pkg::TEAL_XFER: begin
               // a read keeps running to its normal end after the block is cut
               if (abort_wr) begin
                  state_q <= teal_pkg::TEAL_WEND; // see RL11
               end else if (op_done_i) begin
                  state_q <= teal_pkg::TEAL_IDLE; // see RL10
               end
            end
            teal_pkg::TEAL_WEND: begin
               if (gap_done_i) begin
                  state_q <= teal_pkg::TEAL_IDLE; // see RL11
               end
            end
            default: state_q <= teal_pkg::TEAL_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         fn_q <= teal_pkg::TEAL_FN_NOP;
         go_q <= 1'b0;
         motion_start_o <= 1'b0;
      end else begin
         motion_start_o <= start & (fn_new != teal_pkg::TEAL_FN_NOP) & (fn_new != teal_pkg::TEAL_FN_DRV_CLEAR);
         if (ctl_load) begin
            fn_q <= fn_new;
         end
         // load refused for an error present leaves go clear
         if (start && (fn_data || (fn_new == teal_pkg::TEAL_FN_ERASE) || (fn_new == teal_pkg::TEAL_FN_WR_MARK) ||
                       (fn_new == teal_pkg::TEAL_FN_SPACE_FWD) || (fn_new == teal_pkg::TEAL_FN_SPACE_REV))) begin
            go_q <= 1'b1;
         end else if (op_end || prior_fault_block) begin
            go_q <= 1'b0; // see RL22
         end
      end
   end

   // events seen while an operation runs, reported at its end
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         op_event_q <= 1'b0;
      end else if (start) begin
         op_event_q <= 1'b0;
      end else if (busy_any && (any_err_set || slave_change_i || end_marker_i)) begin
         op_event_q <= 1'b1; // see RL4 see RL5
      end
   end

   assign service_request_line_set = prior_fault_block | ilf_set | // see RL3 see RL22
                     (start & (fn_new == teal_pkg::TEAL_FN_REWIND)) | // see RL2
                     (op_end & (fn_motion | op_event_q | any_err_set | slave_change_i | end_marker_i)); // see RL1 see RL4 see RL5
   assign service_request_line_clear = (wr_ok & (reg_sel_i == `TEAL_IDX_SERVICE_REQUEST_LINE_SUM) & ctl_data_i[unit_num_i]) | drv_clear; // see RL24

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         attention_active_flag_q <= 1'b0;
         slave_change_flag_q <= 1'b0;
      end else begin
         attention_active_flag_q <= service_request_line_set | (attention_active_flag_q & ~service_request_line_clear); // see RL24
         slave_change_flag_q <= slave_change_i | (slave_change_flag_q & ~drv_clear);
      end
   end

   assign service_request_line_o = attention_active_flag_q; // see RL25

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         fault_q <= 1'b0;
      end else if (xfer_busy && any_err_set) begin
         fault_q <= 1'b1; // see RL9
      end else if (start || op_end) begin
         fault_q <= 1'b0;
      end
   end

   // end of block is one pulse per transfer
   assign ebl_fire = (prior_fault_block & fn_data) | // see RL12
                     (~ebl_sent_q & (((state_q == teal_pkg::TEAL_XSTART) & any_err_set) | // see RL13
                                     (((state_q == teal_pkg::TEAL_XFER) | (state_q == teal_pkg::TEAL_WEND)) & invalid)));

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ebl_q <= 1'b0;
         ebl_sent_q <= 1'b0;
      end else begin
         ebl_q <= ebl_fire;
         if (start) begin
            ebl_sent_q <= 1'b0;
         end else if (ebl_fire) begin
            ebl_sent_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         maint_q <= `TEAL_REG16_RST;
         tape_ctl_q <= `TEAL_REG16_RST;
      end else if (wr_ok && (reg_sel_i == `TEAL_IDX_MAINT)) begin
         maint_q <= ctl_data_i;
      end else if (wr_ok && !busy_any && (reg_sel_i == `TEAL_IDX_TAPE_CTL)) begin
         tape_ctl_q <= ctl_data_i;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ctl_data_o <= 16'h0000;
         ctl_oe_o <= 1'b0;
         reg_ack_o <= 1'b0;
      end else begin
         reg_ack_o <= acc_ok;
         ctl_oe_o <= rd & legal;
         ctl_data_o <= 16'h0000;
         if (rd) begin
            if (reg_sel_i == `TEAL_IDX_CTRL) begin
               ctl_data_o <= {10'h000, fn_q, go_q};
            end else if (reg_sel_i == `TEAL_IDX_STAT) begin
               ctl_data_o <= {attention_active_flag_q, composite_fault, medium_on_line_i, end_marker_i,
                              10'h000, slave_change_flag_q, drive_busy_line_o};
            end else if (reg_sel_i == `TEAL_IDX_ERR) begin
               ctl_data_o <= err_q;
            end else if (reg_sel_i == `TEAL_IDX_MAINT) begin
               ctl_data_o <= maint_q;
            end else if (reg_sel_i == `TEAL_IDX_SERVICE_REQUEST_LINE_SUM) begin
               ctl_data_o <= {15'h0000, attention_active_flag_q} << unit_num_i; // see RL23
            end else if (reg_sel_i == `TEAL_IDX_TAPE_CTL) begin
               ctl_data_o <= tape_ctl_q;
            end
         end
      end
   end

   assign drive_busy_line_o = xfer_busy; // see RL22
   assign transfer_fault_line_o = fault_q;
   assign end_of_block_line_o = ebl_q;
   assign write_end_o = (state_q == teal_pkg::TEAL_WEND);
   assign function_o = fn_q;

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);

   sequence s_bad_go;
      go_load && composite_fault;
   endsequence

   a_rewind_service_request_line: assert property (start && fn_new == teal_pkg::TEAL_FN_REWIND |=> service_request_line_o) // see RL2
      else $error("rewind start did not raise attention");
   a_prior_block: assert property (s_bad_go |=> !drive_busy_line_o && !go_q && attention_active_flag_q) // see RL22
      else $error("load with error present was not refused");
   a_summary_clr: assert property (service_request_line_clear && !service_request_line_set |=> !service_request_line_o) // see RL24
      else $error("summary write did not clear attention");
   a_summary_read: assert property (rd && reg_sel_i == `TEAL_IDX_SERVICE_REQUEST_LINE_SUM && attention_active_flag_q
                                    |=> ctl_oe_o && ctl_data_o[unit_num_i]) // see RL23
      else $error("summary read missed own line");
   a_fault_line: assert property (xfer_busy && any_err_set |=> transfer_fault_line_o) // see RL9
      else $error("error in transfer did not raise fault line");
   a_not_safe: assert property (!medium_on_line_i |=> err_q[`TEAL_EB_NOT_SAFE] && composite_fault) // see RL19
      else $error("lost medium did not set unsafe");
   a_write_abort: assert property (state_q == teal_pkg::TEAL_XFER && fn_write && invalid
                                   |=> write_end_o && drive_busy_line_o) // see RL11
      else $error("write error did not end the write");
   a_read_runs: assert property (state_q == teal_pkg::TEAL_XFER && !fn_write && invalid && !op_done_i
                                 |=> state_q == teal_pkg::TEAL_XFER) // see RL10
      else $error("read stopped on data error");
   a_data_gate: assert property (state_q == teal_pkg::TEAL_XFER && !ebl_sent_q &&
                                 !(|(err_set & `TEAL_INVALID_MASK)) && (|(err_set & `TEAL_DATA_MASK))
                                 |=> end_of_block_line_o == $past(tape_ctl_q[`TEAL_TC_ABORT_EN])) // see RL15
      else $error("data error end of block not gated by enable");
   a_motion_end: assert property (state_q == teal_pkg::TEAL_MOTION && op_done_i && fn_motion
                                  ##1 !$past(service_request_line_clear) |-> service_request_line_o) // see RL1
      else $error("motion completion did not raise attention");
   a_prior_ebl: assert property (s_bad_go ##0 fn_data |=> end_of_block_line_o ##1 !end_of_block_line_o) // see RL12
      else $error("transfer tried with error gave no single end of block");

endmodule : teal_attention_unit

// file: core/teal_error_reg.sv
// sticky error flags with composite fault
`timescale 1ns/100ps
`include "teal_regs.svh"
module teal_error_reg #(
   parameter int WIDTH = 16
) (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic [WIDTH-1:0] set_i,
   input wire logic clear_i,
   output logic [WIDTH-1:0] err_o,
   output logic composite_o
);

   localparam logic [WIDTH-1:0] RST_VAL = WIDTH'(`TEAL_ERR_RST);

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         // a new error in the clearing cycle survives
         always_ff @(posedge sys_clk_i or posedge rst_i) begin
            if (rst_i) begin
               err_o[i] <= RST_VAL[i];
            end else begin
               err_o[i] <= set_i[i] | (err_o[i] & ~clear_i);
            end
         end
      end
   endgenerate

   assign composite_o = |err_o; // see RL22

endmodule : teal_error_reg

// file: core/teal_pkg.sv
// types of the tape error and attention logic
package teal_pkg;

   typedef enum logic [2:0] {
      TEAL_IDLE = 3'b000,
      TEAL_MOTION = 3'b001,
      TEAL_XSTART = 3'b010,
      TEAL_XFER = 3'b011,
      TEAL_WEND = 3'b100
   } teal_state_e;

   typedef enum logic [4:0] {
      TEAL_FN_NOP = 5'h00,
      TEAL_FN_REWIND = 5'h03,
      TEAL_FN_DRV_CLEAR = 5'h04,
      TEAL_FN_ERASE = 5'h0a,
      TEAL_FN_WR_MARK = 5'h0b,
      TEAL_FN_SPACE_FWD = 5'h0c,
      TEAL_FN_SPACE_REV = 5'h0d,
      TEAL_FN_WR_CHECK = 5'h14,
      TEAL_FN_WRITE = 5'h18,
      TEAL_FN_READ_FWD = 5'h1c,
      TEAL_FN_READ_REV = 5'h1f
   } teal_func_e;

endpackage : teal_pkg

// file: core/teal_regs.svh
// register indices, field positions and reset values of the tape error and attention logic
`ifndef TEAL_REGS_SVH
`define TEAL_REGS_SVH

`define TEAL_IDX_CTRL 5'h00
`define TEAL_IDX_STAT 5'h01
`define TEAL_IDX_ERR 5'h02
`define TEAL_IDX_MAINT 5'h03
`define TEAL_IDX_SERVICE_REQUEST_LINE_SUM 5'h04
// octal 11; indices above this one do not exist
`define TEAL_IDX_TAPE_CTL 5'h09

`define TEAL_CTL_GO 0
`define TEAL_CTL_FN_LSB 1
`define TEAL_CTL_FN_MSB 5
`define TEAL_TC_ABORT_EN 12

`define TEAL_ST_BUSY 0
`define TEAL_ST_SLAVE_CHG 1
`define TEAL_ST_END_MARK 12
`define TEAL_ST_MOL 13
`define TEAL_ST_COMPOSITE 14
`define TEAL_ST_SERVICE_REQUEST_LINE 15

`define TEAL_EB_BAD_FN 0
`define TEAL_EB_BAD_REG 1
`define TEAL_EB_MOD_REFUSED 2
`define TEAL_EB_CTL_PAR 3
`define TEAL_EB_FORMAT 4
`define TEAL_EB_DATA_PAR 5
`define TEAL_EB_VPAR 6
`define TEAL_EB_LCHK 7
`define TEAL_EB_FRAME_CNT 9
`define TEAL_EB_UNRUNNABLE 11
`define TEAL_EB_TIMING 12
`define TEAL_EB_OP_INCOMPLETE 13
`define TEAL_EB_NOT_SAFE 14
`define TEAL_EB_CCHK 15

`define TEAL_INVALID_MASK 16'h7001
`define TEAL_DATA_MASK 16'h80e0

`define TEAL_ERR_RST 16'h0000
`define TEAL_REG16_RST 16'h0000
`define TEAL_FN_RST 5'h00

`endif

// file: tb/tb_top.sv
// self-checking bench of the tape error and attention logic
`timescale 1ns/100ps
`include "teal_regs.svh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module tb_top;
   logic sys_clk_i, rst_i, drive_sel_match_i, reg_strobe_i, reg_write_i, ctl_parity_err_i;
   logic medium_on_line_i, ac_power_low_i, end_marker_i, slave_change_i, ctl_oe_o, reg_ack_o;
   logic service_request_line_o, drive_busy_line_o, transfer_fault_line_o, end_of_block_line_o;
   logic motion_start_o, write_end_o, op_done_i, gap_done_i, seen_srq, seen_ebl, seen_busy;
   logic format_err_i, data_parity_err_i, frame_count_err_i, unrunnable_err_i, timing_err_i;
   logic op_incomplete_err_i, vpar_err_i, lchk_err_i, cchk_err_i;
   logic [2:0] unit_num_i;
   logic [4:0] reg_sel_i, function_o, dly;
   logic [15:0] ctl_data_i, ctl_data_o;
   logic [8:0] errs;
   int failures, cmp_count, j;
   int cycles = 0;
   assign {cchk_err_i, lchk_err_i, vpar_err_i, op_incomplete_err_i, timing_err_i, unrunnable_err_i,
      frame_count_err_i, data_parity_err_i, format_err_i} = errs;
   teal_attention_unit dut (.*);
   teal_xport_model xport (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .start_i(motion_start_o),
      .wend_i(write_end_o), .delay_i(dly), .op_done_o(op_done_i), .gap_done_o(gap_done_i));
   // order: the nine error inputs of errs, then lost medium, then low ac
   function automatic logic [15:0] emask(input int i);
      logic [15:0] t [11];
      t = '{16'h0010, 16'h0020, 16'h0200, 16'h0800, 16'h1000, 16'h2000, 16'h0040, 16'h0080,
         16'h8000, 16'h4000, 16'h4000};
      return t[i];
   endfunction : emask
   // invalidating errors always end the block, data errors only when enabled
   function automatic logic ebl_exp(input int i, input logic ab);
      return ((emask(i) & 16'h7001) != 16'h0000) || (ab && ((emask(i) & 16'h80e0) != 16'h0000));
   endfunction : ebl_exp
   task automatic complete_run;
      if (failures == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : complete_run
   task automatic do_rst;
      @(posedge sys_clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      #1;
   endtask : do_rst
   task automatic acc(input logic w, input logic [4:0] s, input logic [15:0] d, input logic p);
      @(posedge sys_clk_i);
      reg_strobe_i <= 1'b1;
      reg_write_i <= w;
      reg_sel_i <= s;
      ctl_data_i <= d;
      ctl_parity_err_i <= p;
      @(posedge sys_clk_i);
      reg_strobe_i <= 1'b0;
      #1;
   endtask : acc
   task automatic go(input logic [4:0] fn);
      acc(1'b1, `TEAL_IDX_CTRL, {10'h000, fn, 1'b1}, 1'b0);
   endtask : go
   task automatic inj(input int i);
      @(posedge sys_clk_i);
      if (i < 9) errs[i] <= 1'b1;
      else if (i == 9) medium_on_line_i <= 1'b0;
      else ac_power_low_i <= 1'b1;
      @(posedge sys_clk_i);
      errs <= 9'h000;
      medium_on_line_i <= 1'b1;
      ac_power_low_i <= 1'b0;
      #1;
   endtask : inj
   task automatic watch(input int n);
      seen_srq = 1'b0;
      seen_ebl = 1'b0;
      seen_busy = 1'b0;
      repeat (n) begin
         @(posedge sys_clk_i);
         #1;
         seen_srq |= service_request_line_o;
         seen_ebl |= end_of_block_line_o;
         seen_busy |= drive_busy_line_o;
      end
   endtask : watch
   initial begin
      sys_clk_i = 1'b0;
      forever #25 sys_clk_i = ~sys_clk_i;
   end
   always @(posedge sys_clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         complete_run;
      end
   end
   initial begin
      {rst_i, drive_sel_match_i, medium_on_line_i} = 3'h7;
      {reg_strobe_i, reg_write_i, ctl_parity_err_i, ac_power_low_i, end_marker_i, slave_change_i} = 6'h00;
      {unit_num_i, reg_sel_i, ctl_data_i, errs} = 33'h0;
      dly = 5'h08;
      failures = 0;
      cmp_count = 0;
      void'($urandom(83));
      do_rst;
      acc(1'b0, `TEAL_IDX_ERR, 16'h0000, 1'b0);
      `CHK("err_reset", `TEAL_ERR_RST, ctl_data_o)
      for (j = 0; j < 11; j++) begin
         do_rst;
         inj(j);
         acc(1'b0, `TEAL_IDX_ERR, 16'h0000, 1'b0);
         `CHK("err_map", emask(j), ctl_data_o)
      end
      do_rst;
      acc(1'b0, 5'(10 + $urandom % 22), 16'h0000, 1'b0);
      `CHK("bad_reg_oe", 1'b0, ctl_oe_o)
      `CHK("bad_reg_ack", 1'b1, reg_ack_o)
      acc(1'b0, `TEAL_IDX_ERR, 16'h0000, 1'b0);
      `CHK("read_err", 16'h0002, ctl_data_o)
      go(teal_pkg::TEAL_FN_READ_FWD);
      `CHK("go_err_ebl", 1'b1, end_of_block_line_o)
      watch(3);
      `CHK("go_err_service_request_line", 1'b1, seen_srq)
      `CHK("go_err_busy", 1'b0, seen_busy)
      do_rst;
      acc(1'b1, `TEAL_IDX_SERVICE_REQUEST_LINE_SUM, 16'hffff, 1'b1);
      acc(1'b1, `TEAL_IDX_CTRL, 16'h0000, 1'b1);
      acc(1'b0, `TEAL_IDX_ERR, 16'h0000, 1'b0);
      `CHK("par_err", 16'h0008, ctl_data_o)
      for (j = 0; j < 4; j++) begin
         do_rst;
         dly <= 5'(3 + $urandom % 16);
         unit_num_i <= 3'($urandom % 8);
         go(j == 0 ? teal_pkg::TEAL_FN_ERASE : j == 1 ? teal_pkg::TEAL_FN_WR_MARK :
            j == 2 ? teal_pkg::TEAL_FN_SPACE_FWD : teal_pkg::TEAL_FN_SPACE_REV);
         `CHK("motion_service_request_line_early", 1'b0, service_request_line_o)
         watch(30);
         `CHK("motion_service_request_line", 1'b1, seen_srq)
         drive_sel_match_i <= 1'b0;
         acc(1'b0, `TEAL_IDX_SERVICE_REQUEST_LINE_SUM, 16'h0000, 1'b0);
         `CHK("sum_read", 1'b1, ctl_data_o[unit_num_i])
         acc(1'b1, `TEAL_IDX_SERVICE_REQUEST_LINE_SUM, 16'($urandom) & ~(16'h0001 << unit_num_i), 1'b0);
         watch(1);
         `CHK("sum_keep", 1'b1, service_request_line_o)
         acc(1'b1, `TEAL_IDX_SERVICE_REQUEST_LINE_SUM, 16'h0001 << unit_num_i, 1'b0);
         watch(1);
         `CHK("sum_clear", 1'b0, service_request_line_o)
         drive_sel_match_i <= 1'b1;
      end
      do_rst;
      go(teal_pkg::TEAL_FN_REWIND);
      watch(2);
      `CHK("rewind_service_request_line", 1'b1, seen_srq)
      `CHK("rewind_fn", teal_pkg::TEAL_FN_REWIND, function_o)
      for (j = 0; j < 2; j++) begin
         do_rst;
         end_marker_i <= (j == 0);
         go(teal_pkg::TEAL_FN_READ_FWD);
         slave_change_i <= (j == 1);
         watch(1);
         slave_change_i <= 1'b0;
         watch(30);
         `CHK("end_service_request_line", 1'b1, seen_srq)
         acc(1'b0, `TEAL_IDX_STAT, 16'h0000, 1'b0);
         `CHK("stat_poll", {j == 0, j == 1}, {ctl_data_o[`TEAL_ST_END_MARK], ctl_data_o[`TEAL_ST_SLAVE_CHG]})
         end_marker_i <= 1'b0;
      end
      for (j = 0; j < 18; j++) begin
         do_rst;
         dly <= 5'(8 + $urandom % 16);
         if (j % 2 == 1) acc(1'b1, `TEAL_IDX_TAPE_CTL, 16'h1000, 1'b0);
         go(teal_pkg::TEAL_FN_READ_FWD);
         inj(j / 2);
         `CHK("xfer_ebl", ebl_exp(j / 2, j % 2 == 1), end_of_block_line_o)
         `CHK("xfer_fault", 1'b1, transfer_fault_line_o)
         `CHK("read_runs_on", 1'b1, drive_busy_line_o)
         watch(30);
         `CHK("xfer_service_request_line", 1'b1, seen_srq)
         `CHK("xfer_idle", 1'b0, drive_busy_line_o)
         acc(1'b0, `TEAL_IDX_STAT, 16'h0000, 1'b0);
         `CHK("xfer_stat_err", 1'b1, ctl_data_o[`TEAL_ST_COMPOSITE])
         acc(1'b0, `TEAL_IDX_ERR, 16'h0000, 1'b0);
         `CHK("xfer_err_reg", emask(j / 2), ctl_data_o)
      end
      do_rst;
      dly <= 5'(8 + $urandom % 16);
      go(teal_pkg::TEAL_FN_WRITE);
      inj(4);
      `CHK("wr_ebl", 1'b1, end_of_block_line_o)
      `CHK("wr_end", 1'b1, write_end_o)
      acc(1'b1, `TEAL_IDX_CTRL, 16'h0001, 1'b0);
      acc(1'b0, `TEAL_IDX_ERR, 16'h0000, 1'b0);
      `CHK("wr_refused", 16'h1004, ctl_data_o)
      watch(40);
      `CHK("wr_gap_done", 1'b0, write_end_o)
      `CHK("wr_service_request_line", 1'b1, seen_srq)
      // error lands in the single start cycle of the transfer
      do_rst;
      go(teal_pkg::TEAL_FN_READ_REV);
      errs[0] <= 1'b1;
      watch(1);
      errs <= 9'h000;
      `CHK("start_ebl", 1'b1, seen_ebl)
      `CHK("start_fault", 1'b1, transfer_fault_line_o)
      complete_run;
   end
endmodule : tb_top

// file: tb/teal_xport_model.sv
// transport stand-in: ends operations and erased gaps after a set delay
`timescale 1ns/100ps
module teal_xport_model (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic start_i,
   input wire logic wend_i,
   input wire logic [4:0] delay_i,
   output logic op_done_o,
   output logic gap_done_o
);
   logic [4:0] op_cnt_q;
   logic [4:0] gap_cnt_q;
   logic wend_q;
   // tape keeps moving to its own end even after the bus transfer was cut short
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         op_cnt_q <= 5'h00;
         op_done_o <= 1'b0;
      end else begin
         op_done_o <= (op_cnt_q == 5'h01);
         if (start_i) begin
            op_cnt_q <= delay_i;
         end else if (op_cnt_q != 5'h00) begin
            op_cnt_q <= op_cnt_q - 5'h01;
         end
      end
   end
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         gap_cnt_q <= 5'h00;
         gap_done_o <= 1'b0;
         wend_q <= 1'b0;
      end else begin
         wend_q <= wend_i;
         gap_done_o <= (gap_cnt_q == 5'h01);
         if (wend_i && !wend_q) begin
            gap_cnt_q <= delay_i;
         end else if (gap_cnt_q != 5'h00) begin
            gap_cnt_q <= gap_cnt_q - 5'h01;
         end
      end
   end
endmodule : teal_xport_model
